//--- design/cmd_pkg.sv
// Package of constants for the counter command decoder.
package cmd_pkg;
  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int          NUM_COUNTERS     = 5;
  localparam int          COUNT_W          = 16;
  // ------------------------------------------------------------------
  // Command encodings
  // ------------------------------------------------------------------
  localparam logic [2:0]  GRP_LOAD_PTR     = 3'h0;
  localparam logic [2:0]  GRP_ARM          = 3'h1;
  localparam logic [2:0]  GRP_LOAD         = 3'h2;
  localparam logic [2:0]  GRP_LOAD_ARM     = 3'h3;
  localparam logic [2:0]  GRP_DISARM_SAVE  = 3'h4;
  localparam logic [2:0]  GRP_SAVE         = 3'h5;
  localparam logic [2:0]  GRP_DISARM       = 3'h6;
  localparam logic [2:0]  GRP_SPECIAL      = 3'h7;
  localparam logic [1:0]  SUB_CLR_TOGGLE   = 2'h0;
  localparam logic [1:0]  SUB_SET_TOGGLE   = 2'h1;
  localparam logic [1:0]  SUB_STEP         = 2'h2;
  localparam logic [7:0]  CMD_SEQ_OFF      = 8'hE8;
  localparam logic [7:0]  CMD_SEQ_ON       = 8'hE0;
  localparam logic [7:0]  CMD_WIDE_ON      = 8'hEF;
  localparam logic [7:0]  CMD_WIDE_OFF     = 8'hE7;
  localparam logic [7:0]  CMD_FREQ_OUTPUT_PIN_OFF     = 8'hEE;
  localparam logic [7:0]  CMD_FREQ_OUTPUT_PIN_ON      = 8'hE6;
  localparam logic [7:0]  CMD_PREFETCH_ON  = 8'hF8;
  localparam logic [7:0]  CMD_PREFETCH_OFF = 8'hF9;
  localparam logic [7:0]  CMD_MASTER_RESET = 8'hFF;
  // ------------------------------------------------------------------
  // Master-mode and counter-mode bit positions and reset values
  // ------------------------------------------------------------------
  localparam int          MM_SEQ_BIT       = 14;
  localparam int          MM_WIDE_BIT      = 13;
  localparam int          MM_FREQ_OUTPUT_PIN_BIT      = 12;
  localparam logic [15:0] MASTER_RESET_VAL = 16'h0000;
  localparam logic [15:0] CMODE_RESET_VAL  = 16'h0800;
  localparam logic [15:0] REG_RESET_VAL    = 16'h0000;
  localparam int          CM_UP_BIT        = 3;
  localparam int          CM_OUT_LSB       = 0;
  localparam logic [2:0]  OUT_MODE_TOGGLE  = 3'h2;
  // ------------------------------------------------------------------
  // Data pointer groups that are not accepted
  // ------------------------------------------------------------------
  localparam logic [2:0]  PTR_GROUP_BAD0   = 3'h0;
  localparam logic [2:0]  PTR_GROUP_BAD1   = 3'h6;
endpackage

//--- design/counter_command_decoder.sv
// Command decoder and executor for a five-counter timing controller.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
module counter_command_decoder
  import cmd_pkg::*;
#(
  parameter int N = NUM_COUNTERS,
  parameter int W = COUNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             cmd_write,
  input  wire logic [7:0]       cmd_code,
  input  wire logic             master_write,
  input  wire logic [15:0]      master_data,
  input  wire logic             mode_write,
  input  wire logic [2:0]       mode_index,
  input  wire logic [15:0]      mode_data,
  input  wire logic             load_reg_write,
  input  wire logic [2:0]       load_reg_index,
  input  wire logic [W-1:0]     load_reg_data,
  input  wire logic [N-1:0]     count_tick,
  input  wire logic             freq_in,
  output logic [15:0]           master_mode_r,
  output logic                  pointer_advance_inhibit,
  output logic                  wide_bus_select,
  output logic                  freq_out_gate_off,
  output logic                  write_prefetch_en_r,
  output logic [1:0]            element_field_r,
  output logic [2:0]            group_field_r,
  output logic                  byte_select_r,
  output logic [N-1:0]          armed,
  output logic [N-1:0]          terminal_count_state,
  output logic [N-1:0]          counter_out,
  output logic [N*W-1:0]        count_values,
  output logic [N*W-1:0]        hold_values,
  output logic                  freq_output_pin,
  output logic                  freq_output_oe
);
  // --------------------------------------------------------------------
  // Command field decode
  // --------------------------------------------------------------------
  logic [2:0]   grp;
  logic [N-1:0] counter_select_bits;
  logic [1:0]   sub;
  logic [2:0]   counter_number_field;
  logic         master_reset;
  logic [15:0]  mode_r     [N];
  logic [W-1:0] load_r     [N];
  logic [N-1:0] toggle_q;

  assign grp                  = cmd_code[7:5];
  assign counter_select_bits  = cmd_code[N-1:0];
  assign sub                  = cmd_code[4:3];
  assign counter_number_field = cmd_code[2:0];
  assign master_reset         = cmd_write && (cmd_code == CMD_MASTER_RESET);

  // One-hot select of counter N from its 3-bit number; 0, 6 and 7 pick none.
  function automatic logic [NUM_COUNTERS-1:0] number_onehot(input logic [2:0] num);
    logic [NUM_COUNTERS-1:0] sel;
    sel = '0;
    for (int k = 0; k < NUM_COUNTERS; k++) begin
      if (num == 3'(k + 1)) begin
        sel[k] = 1'b1;
      end
    end
    return sel;
  endfunction

  function automatic logic is_grp(input logic [7:0] code, input logic [2:0] g);
    return code[7:5] == g;
  endfunction

  // --------------------------------------------------------------------
  // Per-counter strobes
  // --------------------------------------------------------------------
  logic [N-1:0] num_sel;
  logic [N-1:0] s_arm;
  logic [N-1:0] s_load;
  logic [N-1:0] s_load_arm;
  logic [N-1:0] s_disarm;
  logic [N-1:0] s_save;
  logic [N-1:0] s_step;
  logic [N-1:0] s_tset;
  logic [N-1:0] s_tclr;
  logic         special;

  assign num_sel = number_onehot(counter_number_field);
  assign special = cmd_write && is_grp(cmd_code, GRP_SPECIAL);

  always_comb begin
    s_arm      = '0;
    s_load     = '0;
    s_load_arm = '0;
    s_disarm   = '0;
    s_save     = '0;
    s_step     = '0;
    s_tset     = '0;
    s_tclr     = '0;
    if (cmd_write) begin
      case (grp)
        GRP_ARM:         s_arm      = counter_select_bits;
        GRP_LOAD:        s_load     = counter_select_bits;
        GRP_LOAD_ARM:    s_load_arm = counter_select_bits;
        GRP_DISARM: begin
          s_disarm = counter_select_bits;
        end
        GRP_SAVE: begin
          s_save = counter_select_bits;
        end
        GRP_DISARM_SAVE: begin
          s_disarm = counter_select_bits;
          s_save   = counter_select_bits;
        end
        GRP_SPECIAL: begin
          case (sub)
            SUB_SET_TOGGLE: s_tset = num_sel;
            SUB_CLR_TOGGLE: s_tclr = num_sel;
            SUB_STEP:       s_step = num_sel;
            default:        s_step = '0;
          endcase
        end
        default: s_arm = '0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Counter mode and load registers
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_cnt
      always_ff @(posedge clk) begin
        if (!rst_b || master_reset) begin
          mode_r[gi] <= CMODE_RESET_VAL;
          load_r[gi] <= W'(REG_RESET_VAL);
        end else begin
          if (mode_write && mode_index == 3'(gi + 1)) begin
            mode_r[gi] <= mode_data;
          end
          if (load_reg_write && load_reg_index == 3'(gi + 1)) begin
            load_r[gi] <= load_reg_data;
          end
        end
      end

      counter_slice #(
        .W(W)
      ) u_slice (
        .clk          (clk),
        .rst_b        (rst_b),
        .master_reset (master_reset),
        .count_tick   (count_tick[gi]),
        .arm_cmd      (s_arm[gi]),
        .load_cmd     (s_load[gi]),
        .load_arm_cmd (s_load_arm[gi]),
        .disarm_cmd   (s_disarm[gi]),
        .save_cmd     (s_save[gi]),
        .step_cmd     (s_step[gi]),
        .toggle_set   (s_tset[gi]),
        .toggle_clr   (s_tclr[gi]),
        .mode_value   (mode_r[gi]),
        .load_value   (load_r[gi]),
        .armed_r      (armed[gi]),
        .tc_r         (terminal_count_state[gi]),
        .toggle_r     (toggle_q[gi]),
        .out_level    (counter_out[gi]),
        .count_r      (count_values[gi*W +: W]),
        .hold_r       (hold_values[gi*W +: W])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Master mode register
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b || master_reset) begin
      master_mode_r <= MASTER_RESET_VAL;
    end else if (special) begin
      case (cmd_code)
        CMD_SEQ_OFF:  master_mode_r[MM_SEQ_BIT]  <= 1'b1;
        CMD_SEQ_ON:   master_mode_r[MM_SEQ_BIT]  <= 1'b0;
        CMD_WIDE_ON:  master_mode_r[MM_WIDE_BIT] <= 1'b1;
        CMD_WIDE_OFF: master_mode_r[MM_WIDE_BIT] <= 1'b0;
        CMD_FREQ_OUTPUT_PIN_OFF: master_mode_r[MM_FREQ_OUTPUT_PIN_BIT] <= 1'b1;
        CMD_FREQ_OUTPUT_PIN_ON:  master_mode_r[MM_FREQ_OUTPUT_PIN_BIT] <= 1'b0;
        default:      master_mode_r              <= master_mode_r;
      endcase
    end else if (master_write) begin
      master_mode_r <= master_data;
    end
  end

  assign pointer_advance_inhibit = master_mode_r[MM_SEQ_BIT];
  assign wide_bus_select         = master_mode_r[MM_WIDE_BIT];
  assign freq_out_gate_off       = master_mode_r[MM_FREQ_OUTPUT_PIN_BIT];

  // --------------------------------------------------------------------
  // Write prefetch
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b || master_reset) begin
      write_prefetch_en_r <= 1'b1;
    end else if (special && cmd_code == CMD_PREFETCH_OFF) begin
      write_prefetch_en_r <= 1'b0;
    end else if (special && cmd_code == CMD_PREFETCH_ON) begin
      write_prefetch_en_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Data pointer; reset leaves it unset by design, so zero it on rst_b only
  // --------------------------------------------------------------------
  logic ptr_load;
  assign ptr_load = cmd_write && is_grp(cmd_code, GRP_LOAD_PTR)
                  && cmd_code[2:0] != PTR_GROUP_BAD0
                  && cmd_code[2:0] != PTR_GROUP_BAD1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      element_field_r <= 2'h0;
      group_field_r   <= 3'h0;
      byte_select_r   <= 1'b0;
    end else if (ptr_load) begin
      element_field_r <= cmd_code[4:3];
      group_field_r   <= cmd_code[2:0];
      byte_select_r   <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Frequency output
  // --------------------------------------------------------------------
  freq_out_gate u_freq_output_pin (
    .clk             (clk),
    .rst_b           (rst_b),
    .gate_off        (freq_out_gate_off),
    .freq_in         (freq_in),
    .freq_output_pin (freq_output_pin),
    .freq_output_oe  (freq_output_oe)
  );

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence seq_off_cmd;
    cmd_write && cmd_code == CMD_SEQ_OFF;
  endsequence

  seq_inhibit_set_a: assert property (seq_off_cmd |=> pointer_advance_inhibit)
    else $error("sequencing disable did not set inhibit");
  seq_inhibit_clr_a: assert property (cmd_write && cmd_code == CMD_SEQ_ON
    |=> !pointer_advance_inhibit) else $error("sequencing enable did not clear");
  wide_set_a: assert property (cmd_write && cmd_code == CMD_WIDE_ON
    |=> wide_bus_select && $stable(master_mode_r[MM_SEQ_BIT]))
    else $error("wide bus set wrong");
  wide_clr_a: assert property (cmd_write && cmd_code == CMD_WIDE_OFF
    |=> !wide_bus_select) else $error("wide bus clear wrong");
  freq_output_pin_low_a: assert property (freq_out_gate_off ##1 freq_out_gate_off
    |-> !freq_output_pin) else $error("frequency pin not low when gated");
  prefetch_off_a: assert property (cmd_write && cmd_code == CMD_PREFETCH_OFF
    |=> !write_prefetch_en_r) else $error("prefetch not disabled");
  master_reset_a: assert property (master_reset
    |=> master_mode_r == MASTER_RESET_VAL && armed == '0) else $error("master reset wrong");
  ptr_bad_grp_a: assert property (cmd_write && cmd_code[7:5] == GRP_LOAD_PTR
    && cmd_code[2:0] == PTR_GROUP_BAD1 |=> $stable(group_field_r))
    else $error("pointer loaded with illegal group");
  save_hold_a: assert property (s_save[0]
    |=> hold_values[W-1:0] == $past(count_values[W-1:0])) else $error("save wrong");
  disarm_a: assert property (s_disarm[0] && !terminal_count_state[0] && !s_load_arm[0]
    |=> !armed[0]) else $error("disarm did not stop counter");

  // Steps act whether or not the counter is armed, so arming is not in the antecedent.
  sequence step_down_seq;
    s_step[0] && !mode_r[0][CM_UP_BIT];
  endsequence

  sequence step_up_seq;
    s_step[0] && mode_r[0][CM_UP_BIT];
  endsequence

  step_down_a: assert property (step_down_seq
    |=> count_values[W-1:0] == $past(count_values[W-1:0]) - W'(1))
    else $error("step did not count down");
  step_up_a: assert property (step_up_seq
    |=> count_values[W-1:0] == $past(count_values[W-1:0]) + W'(1))
    else $error("step did not count up");
  toggle_set_a: assert property (s_tset != '0
    |=> (toggle_q & $past(s_tset)) == $past(s_tset)) else $error("toggle not set");
  toggle_clr_a: assert property (s_tclr != '0
    |=> (toggle_q & $past(s_tclr)) == '0) else $error("toggle not cleared");
  load_arm_a: assert property (s_load_arm != '0
    |=> (armed & $past(s_load_arm)) == $past(s_load_arm)) else $error("load and arm lost");
  disarm_wait_a: assert property (s_disarm[2] && terminal_count_state[2] && armed[2]
    && !count_tick[2] |=> armed[2]) else $error("disarm did not wait for terminal count");
  disarm_save_a: assert property (cmd_write && grp == GRP_DISARM_SAVE
    && counter_select_bits[1] && !terminal_count_state[1]
    |=> !armed[1] && hold_values[2*W-1:W] == $past(count_values[2*W-1:W]))
    else $error("disarm and save wrong");
  master_word_a: assert property (master_write && !special
    |=> master_mode_r == $past(master_data)) else $error("master word not loaded");
  ptr_load_a: assert property (ptr_load
    |=> byte_select_r && group_field_r == $past(cmd_code[2:0]))
    else $error("data pointer not loaded");
  prefetch_on_a: assert property (cmd_write && cmd_code == CMD_PREFETCH_ON
    |=> write_prefetch_en_r) else $error("prefetch not enabled");
  freq_output_pin_pass_a: assert property (!freq_out_gate_off && freq_in
    |=> freq_output_pin) else $error("frequency pin not passing source");
  unused_code_a: assert property (special && sub == SUB_STEP && num_sel == '0
    |=> $stable(master_mode_r) && $stable(hold_values))
    else $error("unused code changed state");
endmodule

//--- design/counter_slice.sv
// One counter with arm state, pending disarm, hold and toggle flip-flop.
`timescale 1ns/10ps
module counter_slice
  import cmd_pkg::*;
#(
  parameter int W = COUNT_W
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         master_reset,
  input  wire logic         count_tick,
  input  wire logic         arm_cmd,
  input  wire logic         load_cmd,
  input  wire logic         load_arm_cmd,
  input  wire logic         disarm_cmd,
  input  wire logic         save_cmd,
  input  wire logic         step_cmd,
  input  wire logic         toggle_set,
  input  wire logic         toggle_clr,
  input  wire logic [15:0]  mode_value,
  input  wire logic [W-1:0] load_value,
  output logic              armed_r,
  output logic              tc_r,
  output logic              toggle_r,
  output logic              out_level,
  output logic [W-1:0]      count_r,
  output logic [W-1:0]      hold_r
);
  logic         disarm_pend_r;
  logic         up;
  logic         advance;
  logic         leave_tc;
  logic [W-1:0] count_nxt;
  logic         hits_tc;

  assign up       = mode_value[CM_UP_BIT];
  // Source ticks advance only while armed; a step ignores arming.
  assign advance  = (count_tick && armed_r) || step_cmd;
  assign leave_tc = tc_r && (advance || load_cmd || load_arm_cmd);
  assign count_nxt = up ? count_r + W'(1) : count_r - W'(1);
  assign hits_tc  = up ? (count_nxt == '1) : (count_nxt == '0);

  // --------------------------------------------------------------------
  // Arm state
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b || master_reset) begin
      armed_r       <= 1'b0;
      disarm_pend_r <= 1'b0;
    end else if (load_arm_cmd) begin
      armed_r       <= 1'b1;
      disarm_pend_r <= 1'b0;
    end else if (disarm_cmd && tc_r && !leave_tc) begin
      disarm_pend_r <= 1'b1;
    end else if (disarm_cmd || (disarm_pend_r && leave_tc)) begin
      armed_r       <= 1'b0;
      disarm_pend_r <= 1'b0;
    end else if (arm_cmd) begin
      armed_r       <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Count, terminal count and hold
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b || master_reset) begin
      count_r <= W'(REG_RESET_VAL);
      tc_r    <= 1'b0;
    end else if (load_cmd || load_arm_cmd) begin
      count_r <= load_value;
      tc_r    <= 1'b0;
    end else if (advance) begin
      count_r <= count_nxt;
      tc_r    <= hits_tc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || master_reset) begin
      hold_r <= W'(REG_RESET_VAL);
    end else if (save_cmd) begin
      hold_r <= count_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || master_reset) begin
      toggle_r <= 1'b0;
    end else if (toggle_set) begin
      toggle_r <= 1'b1;
    end else if (toggle_clr) begin
      toggle_r <= 1'b0;
    end else if (advance && hits_tc) begin
      toggle_r <= !toggle_r;
    end
  end

  // Only toggle mode shows the flip-flop; other modes show the TC level.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_level <= 1'b0;
    end else if (mode_value[CM_OUT_LSB +: 3] == OUT_MODE_TOGGLE) begin
      out_level <= toggle_r;
    end else begin
      out_level <= tc_r;
    end
  end
endmodule

//--- design/freq_out_gate.sv
// Output gating of the frequency output pin.
`timescale 1ns/10ps
module freq_out_gate (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic gate_off,
  input  wire logic freq_in,
  output logic      freq_output_pin,
  output logic      freq_output_oe
);
  // The gate and the pin are both registered on clk, so a change of gating
  // takes effect at a clock edge, with no short pulse on the pin.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      freq_output_pin <= 1'b0;
    end else begin
      freq_output_pin <= gate_off ? 1'b0 : freq_in;
    end
  end

  // Gated off still drives low, so the pin is always driven.
  assign freq_output_oe = 1'b1;
endmodule

//--- testbench/host_model.sv
// Host processor model that writes commands and registers on the parallel bus.
`timescale 1ns/10ps
module host_model (
  input  wire logic        clk,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic             master_write,
  output logic [15:0]      master_data,
  output logic             mode_write,
  output logic [2:0]       mode_index,
  output logic [15:0]      mode_data,
  output logic             load_reg_write,
  output logic [2:0]       load_reg_index,
  output logic [15:0]      load_reg_data
);
  initial begin
    {cmd_write, master_write, mode_write, load_reg_write} = 4'h0;
    {cmd_code, master_data, mode_data, load_reg_data} = 56'h0;
    {mode_index, load_reg_index} = 6'h0;
  end

  // --------------------------------------------------------------------
  // One write of kind k: 0 command, 1 master word, 2 mode, 3 load.
  // --------------------------------------------------------------------
  // Released data are inverted so that a stale value is never mistaken
  // for a held one.
  task automatic wr(input int k, input logic [2:0] idx, input logic [15:0] d);
    @(posedge clk);
    case (k)
      0: begin
        cmd_write <= 1'h1;
        cmd_code  <= d[7:0];
      end
      1: begin
        master_write <= 1'h1;
        master_data  <= d;
      end
      2: begin
        mode_write <= 1'h1;
        mode_index <= idx;
        mode_data  <= d;
      end
      default: begin
        load_reg_write <= 1'h1;
        load_reg_index <= idx;
        load_reg_data  <= d;
      end
    endcase
    @(posedge clk);
    {cmd_write, master_write, mode_write, load_reg_write} <= 4'h0;
    {cmd_code, master_data, mode_data, load_reg_data} <= ~{d[7:0], d, d, d};
    #1;
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking testbench of the counter command decoder.
`timescale 1ns/10ps
module tb;
  import cmd_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [4:0]  count_tick = 5'h0;
  logic        freq_in = 1'b0;
  logic        cmd_write, master_write, mode_write, load_reg_write;
  logic [7:0]  cmd_code;
  logic [15:0] master_data, mode_data, load_reg_data, master_mode_r;
  logic [2:0]  mode_index, load_reg_index, group_field_r;
  logic        pointer_advance_inhibit, wide_bus_select, freq_out_gate_off;
  logic        write_prefetch_en_r, byte_select_r, freq_output_pin, freq_output_oe;
  logic [1:0]  element_field_r;
  logic [4:0]  armed, terminal_count_state, counter_out;
  logic [79:0] count_values, hold_values;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [7:0]  mc [6] = '{8'hE8, 8'hEF, 8'hEE, 8'hE0, 8'hE7, 8'hE6};
  logic [15:0] me [6] = '{16'h4000, 16'h6000, 16'h7000, 16'h3000, 16'h1000, 16'h0000};

  always #2 clk = ~clk;

  host_model host_model_i (.clk, .cmd_write, .cmd_code, .master_write, .master_data,
    .mode_write, .mode_index, .mode_data, .load_reg_write, .load_reg_index,
    .load_reg_data);

  counter_command_decoder counter_command_decoder_i (.clk, .rst_b, .cmd_write,
    .cmd_code, .master_write, .master_data, .mode_write, .mode_index, .mode_data,
    .load_reg_write, .load_reg_index, .load_reg_data, .count_tick, .freq_in,
    .master_mode_r, .pointer_advance_inhibit, .wide_bus_select, .freq_out_gate_off,
    .write_prefetch_en_r, .element_field_r, .group_field_r, .byte_select_r, .armed,
    .terminal_count_state, .counter_out, .count_values, .hold_values,
    .freq_output_pin, .freq_output_oe);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    host_model_i.wr(0, 3'h0, {8'h00, c});
  endtask

  task automatic tick(input int i, input int n);
    repeat (n) begin
      @(posedge clk);
      count_tick[i] <= 1'b1;
    end
    @(posedge clk);
    count_tick[i] <= 1'b0;
    #1;
  endtask

  function automatic logic [15:0] cv(input int i);
    return count_values[i*16 +: 16];
  endfunction

  function automatic logic [15:0] hv(input int i);
    return hold_values[i*16 +: 16];
  endfunction

  // A hang is cut short well past the roughly 120 cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_b   <= 1'b1;
    freq_in <= 1'b1;
    #1;
    chk("prefetch", write_prefetch_en_r, 16'h1);
    for (int k = 0; k < 6; k++) begin
      cmd(mc[k]);
      chk("master", master_mode_r, me[k]);
      chk("mm bits", {pointer_advance_inhibit, wide_bus_select, freq_out_gate_off}, me[k][14:12]);
    end
    host_model_i.wr(1, 3'h0, 16'h7000);
    cmd(8'hE0);
    chk("master word", master_mode_r, 16'h3000);
    cmd(8'hEE);
    repeat (2) @(posedge clk);
    #1;
    chk("freq_output_pin off", {freq_output_oe, freq_output_pin}, 16'h2);
    cmd(8'hE6);
    repeat (2) @(posedge clk);
    #1;
    chk("freq_output_pin on", {freq_output_oe, freq_output_pin}, 16'h3);
    cmd(8'hF9);
    chk("prefetch", write_prefetch_en_r, 16'h0);
    cmd(8'hF8);
    chk("prefetch", write_prefetch_en_r, 16'h1);
    cmd(8'h1D);
    chk("pointer", {element_field_r, group_field_r, byte_select_r}, 16'h3B);
    cmd(8'h06);
    cmd(8'h18);
    chk("pointer", {element_field_r, group_field_r, byte_select_r}, 16'h3B);
    cmd(8'hF6);
    chk("unused", master_mode_r, 16'h2000);
    chk("unused", armed, 16'h0);
    // Counter one: load-and-arm, count, save, disarm, step both ways.
    host_model_i.wr(3, 3'h1, 16'h0005);
    cmd(8'h61);
    tick(0, 2);
    chk("count1", cv(0), 16'h0003);
    cmd(8'hA1);
    chk("hold1", hv(0), 16'h0003);
    cmd(8'hC1);
    tick(0, 2);
    chk("armed", armed, 16'h00);
    chk("count1", cv(0), 16'h0003);
    cmd(8'hF1);
    chk("count1", cv(0), 16'h0002);
    host_model_i.wr(2, 3'h1, 16'h0808);
    cmd(8'hF1);
    chk("count1", cv(0), 16'h0003);
    host_model_i.wr(3, 3'h1, 16'h0009);
    cmd(8'h41);
    chk("count1", cv(0), 16'h0009);
    chk("armed", armed, 16'h00);
    // Toggle preset reaches the output only in mode 010.
    host_model_i.wr(2, 3'h1, 16'h0000);
    cmd(8'hE9);
    @(posedge clk);
    #1;
    chk("out1", counter_out[0], 16'h0);
    host_model_i.wr(2, 3'h1, 16'h0002);
    @(posedge clk);
    #1;
    chk("out1", counter_out[0], 16'h1);
    cmd(8'hE1);
    @(posedge clk);
    #1;
    chk("out1", counter_out[0], 16'h0);
    // Counter two: disarm-and-save.
    host_model_i.wr(3, 3'h2, 16'h0010);
    cmd(8'h62);
    tick(1, 1);
    cmd(8'h82);
    tick(1, 1);
    chk("hold2", hv(1), 16'h000F);
    chk("count2", cv(1), 16'h000F);
    // Counter three: disarm while in terminal count.
    host_model_i.wr(3, 3'h3, 16'h0001);
    cmd(8'h64);
    tick(2, 1);
    chk("tc", terminal_count_state, 16'h04);
    cmd(8'hC4);
    chk("armed", armed, 16'h04);
    tick(2, 1);
    chk("tc", terminal_count_state, 16'h00);
    chk("armed", armed, 16'h00);
    // Counter four: load-and-arm cancels a pending disarm.
    host_model_i.wr(3, 3'h4, 16'h0001);
    cmd(8'h68);
    tick(3, 1);
    cmd(8'hC8);
    cmd(8'h68);
    tick(3, 1);
    chk("armed", armed, 16'h08);
    chk("count4", cv(3), 16'h0000);
    // Master reset after changing master mode and prefetch.
    cmd(8'hE8);
    cmd(8'hF9);
    cmd(8'hFF);
    chk("master", master_mode_r, 16'h0000);
    chk("prefetch", write_prefetch_en_r, 16'h1);
    chk("armed", armed, 16'h00);
    chk("holds", hv(0) | hv(1), 16'h0000);
    chk("count1", cv(0), 16'h0000);
    chk("pointer", {element_field_r, group_field_r, byte_select_r}, 16'h3B);
    print_verdict();
  end
endmodule
